// ===== rtl/fecl_map.svh
// Register offsets, field positions and frame counts of the error-count block.
`ifndef FECL_MAP_SVH
`define FECL_MAP_SVH
`define FECL_OFF_CFG 8'h41
`define FECL_OFF_LCV_HI 8'h42
`define FECL_OFF_LCV_LO 8'h43
`define FECL_OFF_PCV_HI 8'h44
`define FECL_OFF_PCV_LO 8'h45
`define FECL_OFF_OOS_HI 8'h46
`define FECL_OFF_OOS_LO 8'h47
`define FECL_OFF_EB_HI 8'h48
`define FECL_OFF_EB_LO 8'h49
`define FECL_OFF_LOOP 8'h4a
`define FECL_OFF_CHL1 8'h4b
`define FECL_OFF_CHL2 8'h4c
`define FECL_RST_BYTE 8'h00
`define FECL_CFG_MASK 8'h7f
`define FECL_LOOP_MASK 8'h1f
`define FECL_B_EXZ 0
`define FECL_B_MFOOS 1
`define FECL_B_FS_ERROR_REPORT_ENABLE 2
`define FECL_B_E1CV 3
`define FECL_B_ACCUMULATION_MODE_SELECT 4
`define FECL_B_UPDATE_INTERVAL_SELECT 5
`define FECL_B_MANUAL_COUNT_UPDATE 6
`define FECL_B_FLB 0
`define FECL_B_PLB 1
`define FECL_B_RLB 2
`define FECL_B_LLB 3
`define FECL_B_LINE_MUX_CONTROL 4
`define FECL_T1_SHORT_MS 42
`define FECL_E1_SHORT_MS 62.5
`define FECL_T1_SHORT_FRAMES 13'd333
`define FECL_E1_SHORT_FRAMES 13'd500
`define FECL_SECOND_FRAMES 13'd8000
`define FECL_T1_FRAME_BITS 9'd193
`define FECL_E1_FRAME_BITS 9'd256
`define FECL_T1_PAYLOAD_START 9'd1
`define FECL_E1_PAYLOAD_START 9'd8
`endif

// ===== rtl/fecl_pkg.sv
// Types shared by the error-count and loopback block.
package fecl_pkg;
  typedef struct packed {
    logic clk;
    logic frame_start;
    logic line_pos;
    logic line_neg;
    logic rx_data;
    logic fmt_pos;
    logic fmt_neg;
    logic tx_serial;
    logic tx_signaling;
  } fecl_link_type;
  typedef struct packed {
    logic bpv;
    logic cv;
    logic exz;
    logic ft_err;
    logic fs_err;
    logic mf_oos;
    logic ebit;
  } fecl_events_type;
endpackage : fecl_pkg

// ===== rtl/fecl_top.sv
// Error counters, accumulation timing and loopback selection of one framer.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "fecl_map.svh"
module fecl_top import fecl_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic t1_mode,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic line_mux_control,
  input wire fecl_link_type link_pins,
  input wire fecl_events_type event_pins,
  output logic tx_line_pos_out,
  output logic tx_line_neg_out,
  output logic rx_framer_pos,
  output logic rx_framer_neg,
  output logic formatter_data,
  output logic formatter_overhead_regen,
  output logic line_framer_connected,
  output logic jitter_atten_in_loop,
  output logic tx_timing_from_rx,
  output logic rx_timing_from_tx
);
  // Every link-side pin passes two flops before anything looks at it.
  fecl_link_type link_s1_ff, link_s2_ff;
  fecl_events_type ev_s1_ff, ev_s2_ff;
  logic mux_s1_ff, mux_s2_ff;
  logic link_clk_prev_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_s1_ff <= '0;
      link_s2_ff <= '0;
      ev_s1_ff <= '0;
      ev_s2_ff <= '0;
      mux_s1_ff <= 1'b0;
      mux_s2_ff <= 1'b0;
      link_clk_prev_ff <= 1'b0;
    end else begin
      link_s1_ff <= link_pins;
      link_s2_ff <= link_s1_ff;
      ev_s1_ff <= event_pins;
      ev_s2_ff <= ev_s1_ff;
      mux_s1_ff <= line_mux_control;
      mux_s2_ff <= mux_s1_ff;
      link_clk_prev_ff <= link_s2_ff.clk;
    end
  end
  wire link_tick = link_s2_ff.clk & ~link_clk_prev_ff;

  // Register file.
  logic [7:0] cfg_ff, loop_ff, chl1_ff, chl2_ff;
  wire wr_cfg = reg_wr && reg_addr == `FECL_OFF_CFG;
  wire wr_loop = reg_wr && reg_addr == `FECL_OFF_LOOP;
  wire wr_chl1 = reg_wr && reg_addr == `FECL_OFF_CHL1;
  wire wr_chl2 = reg_wr && reg_addr == `FECL_OFF_CHL2;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= `FECL_RST_BYTE;
      loop_ff <= `FECL_RST_BYTE;
      chl1_ff <= `FECL_RST_BYTE;
      chl2_ff <= `FECL_RST_BYTE;
    end else begin
      if (wr_cfg) cfg_ff <= reg_wdata & `FECL_CFG_MASK;
      if (wr_loop) loop_ff <= reg_wdata & `FECL_LOOP_MASK;
      if (wr_chl1) chl1_ff <= reg_wdata;
      if (wr_chl2) chl2_ff <= reg_wdata;
    end
  end
  wire cfg_exz = cfg_ff[`FECL_B_EXZ];
  wire cfg_mfoos = cfg_ff[`FECL_B_MFOOS];
  wire cfg_fs_error_report_enable = cfg_ff[`FECL_B_FS_ERROR_REPORT_ENABLE];
  wire cfg_e1cv = cfg_ff[`FECL_B_E1CV];
  wire cfg_accumulation_mode_select = cfg_ff[`FECL_B_ACCUMULATION_MODE_SELECT];
  wire cfg_update_interval_select = cfg_ff[`FECL_B_UPDATE_INTERVAL_SELECT];
  wire cfg_manual_count_update = cfg_ff[`FECL_B_MANUAL_COUNT_UPDATE];
  wire framer_loop = loop_ff[`FECL_B_FLB];
  wire payload_loop = loop_ff[`FECL_B_PLB];
  wire remote_loop = loop_ff[`FECL_B_RLB];
  wire local_loop = loop_ff[`FECL_B_LLB];
  wire line_mux_bit = loop_ff[`FECL_B_LINE_MUX_CONTROL];
  wire [15:0] chan_loop = {chl2_ff, chl1_ff};

  // Accumulation period: timed by frame count, or by the manual bit.
  logic [12:0] frame_cnt_ff;
  logic manual_count_update_prev_ff;
  wire [12:0] short_frames = t1_mode ? `FECL_T1_SHORT_FRAMES
                                     : `FECL_E1_SHORT_FRAMES;
  wire [12:0] period_frames = cfg_update_interval_select ? short_frames
                                       : `FECL_SECOND_FRAMES;
  wire frame_tick = link_tick & link_s2_ff.frame_start;
  wire period_end = frame_tick && frame_cnt_ff == period_frames - 13'd1;
  wire timed_update = period_end & ~cfg_accumulation_mode_select;
  wire manual_update = cfg_accumulation_mode_select & cfg_manual_count_update & ~manual_count_update_prev_ff;
  wire do_update = timed_update | manual_update;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_cnt_ff <= 13'd0;
      manual_count_update_prev_ff <= 1'b0;
    end else begin
      manual_count_update_prev_ff <= cfg_manual_count_update;
      if (period_end || frame_cnt_ff >= period_frames)
        frame_cnt_ff <= 13'd0;
      else if (frame_tick)
        frame_cnt_ff <= frame_cnt_ff + 13'd1;
    end
  end

  // Event selection for the four counters.
  wire lcv_t1 = ev_s2_ff.bpv | (cfg_exz & ev_s2_ff.exz);
  wire lcv_e1 = cfg_e1cv ? ev_s2_ff.cv : ev_s2_ff.bpv;
  wire pcv_ev = ev_s2_ff.ft_err | (cfg_fs_error_report_enable & ev_s2_ff.fs_err);
  wire oos_ev = cfg_mfoos ? ev_s2_ff.mf_oos
                          : ev_s2_ff.ft_err | ev_s2_ff.fs_err;
  wire [3:0] count_ev = {t1_mode ? lcv_t1 : lcv_e1, pcv_ev, oos_ev,
                         ev_s2_ff.ebit} & {4{link_tick}};

  // Counters saturate so a long interval never wraps back to a small value.
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v,
                                               input logic inc);
    sat_inc = (inc && v != {CNT_W{1'b1}}) ? v + 1'b1 : v;
  endfunction : sat_inc

  logic [CNT_W-1:0] run_ff [4];
  logic [CNT_W-1:0] hold_ff [4];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        run_ff[i] <= '0;
        hold_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (do_update) begin
          // An event in the update cycle starts the new interval.
          hold_ff[i] <= run_ff[i];
          run_ff[i] <= {{(CNT_W-1){1'b0}}, count_ev[3-i]};
        end else begin
          run_ff[i] <= sat_inc(run_ff[i], count_ev[3-i]);
        end
      end
    end
  end

  // Read port: data stand in the cycle after the strobe only.
  logic [7:0] rd_mux;
  wire [CNT_W-1:0] lcv_hold = hold_ff[0];
  wire [CNT_W-1:0] pcv_hold = hold_ff[1];
  wire [CNT_W-1:0] oos_hold = hold_ff[2];
  wire [CNT_W-1:0] eb_hold = hold_ff[3];
  always_comb begin
    unique case (reg_addr)
      `FECL_OFF_CFG: rd_mux = cfg_ff;
      `FECL_OFF_LCV_HI: rd_mux = lcv_hold[15:8];
      `FECL_OFF_LCV_LO: rd_mux = lcv_hold[7:0];
      `FECL_OFF_PCV_HI: rd_mux = pcv_hold[15:8];
      `FECL_OFF_PCV_LO: rd_mux = pcv_hold[7:0];
      `FECL_OFF_OOS_HI: rd_mux = oos_hold[15:8];
      `FECL_OFF_OOS_LO: rd_mux = oos_hold[7:0];
      `FECL_OFF_EB_HI: rd_mux = eb_hold[15:8];
      `FECL_OFF_EB_LO: rd_mux = eb_hold[7:0];
      `FECL_OFF_LOOP: rd_mux = loop_ff;
      `FECL_OFF_CHL1: rd_mux = chl1_ff;
      `FECL_OFF_CHL2: rd_mux = chl2_ff;
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) reg_rdata <= 8'h00;
    else reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end

  // Bit position in the frame, used to find payload bits and channels.
  logic [8:0] bit_pos_ff;
  wire [8:0] frame_bits = t1_mode ? `FECL_T1_FRAME_BITS : `FECL_E1_FRAME_BITS;
  wire [8:0] pay_start = t1_mode ? `FECL_T1_PAYLOAD_START
                                 : `FECL_E1_PAYLOAD_START;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) bit_pos_ff <= 9'd0;
    else if (frame_tick) bit_pos_ff <= 9'd1;
    else if (link_tick)
      bit_pos_ff <= (bit_pos_ff >= frame_bits - 9'd1) ? 9'd0
                                                      : bit_pos_ff + 9'd1;
  end

  // Channel index from bit position: T1 channels start after the F bit,
  // E1 channel n is time slot n+1, so both reduce to (pos - start) / 8.
  function automatic logic [4:0] chan_of(input logic [8:0] pos,
                                         input logic [8:0] start);
    logic [8:0] off;
    off = pos - start;
    chan_of = off[7:3];
  endfunction : chan_of

  // 192 T1 or 248 E1 payload bits per frame; the rest is overhead.
  wire in_payload = bit_pos_ff >= pay_start;
  wire [4:0] chan_idx = chan_of(bit_pos_ff, pay_start);
  wire chan_looped = in_payload && chan_idx < 5'd16 &&
                     chan_loop[chan_idx[3:0]];

  // Data selection toward formatter, line and receive framer.
  wire conn = mux_s2_ff & ~line_mux_bit;
  wire nxt_fmt_data = payload_loop ? (in_payload & link_s2_ff.rx_data)
                    : chan_looped ? link_s2_ff.rx_data
                    : link_s2_ff.tx_serial;
  wire nxt_regen = payload_loop & ~in_payload;
  logic ones_phase_ff;
  wire t1_all_ones = framer_loop & t1_mode;
  wire nxt_tx_pos = remote_loop ? link_s2_ff.line_pos
                  : t1_all_ones ? ones_phase_ff
                  : link_s2_ff.fmt_pos;
  wire nxt_tx_neg = remote_loop ? link_s2_ff.line_neg
                  : t1_all_ones ? ~ones_phase_ff
                  : link_s2_ff.fmt_neg;
  wire tx_into_rx = local_loop | framer_loop;
  wire nxt_rx_pos = tx_into_rx ? link_s2_ff.fmt_pos : link_s2_ff.line_pos;
  wire nxt_rx_neg = tx_into_rx ? link_s2_ff.fmt_neg : link_s2_ff.line_neg;

  // Outputs move on link edges only; flags follow the registers one clock later.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_line_pos_out <= 1'b0;
      tx_line_neg_out <= 1'b0;
      rx_framer_pos <= 1'b0;
      rx_framer_neg <= 1'b0;
      formatter_data <= 1'b0;
      formatter_overhead_regen <= 1'b0;
      ones_phase_ff <= 1'b0;
      line_framer_connected <= 1'b0;
      jitter_atten_in_loop <= 1'b0;
      tx_timing_from_rx <= 1'b0;
      rx_timing_from_tx <= 1'b0;
    end else begin
      if (link_tick) begin
        tx_line_pos_out <= nxt_tx_pos;
        tx_line_neg_out <= nxt_tx_neg;
        rx_framer_pos <= nxt_rx_pos;
        rx_framer_neg <= nxt_rx_neg;
        formatter_data <= nxt_fmt_data;
        formatter_overhead_regen <= nxt_regen;
        ones_phase_ff <= ~ones_phase_ff; // AMI marks alternate polarity.
      end
      line_framer_connected <= conn;
      jitter_atten_in_loop <= local_loop;
      tx_timing_from_rx <= payload_loop;
      // Receive timing from the transmit clock; tying the recovered clock
      // back to the transmit clock in this mode would form a loop.
      rx_timing_from_tx <= framer_loop;
    end
  end

  // Checks.
  a_rd_next_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == `FECL_OFF_LOOP |=> reg_rdata == $past(loop_ff))
    else $error("read data wrong");
  a_idle_read_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without strobe");
  a_update_clears: assert property (@(posedge clk) disable iff (!rst_b)
    do_update |=> hold_ff[0] == $past(run_ff[0]) && run_ff[0] <= 16'd1)
    else $error("update did not latch");
  a_manual_edge: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_accumulation_mode_select && $rose(cfg_manual_count_update) |-> do_update)
    else $error("manual update missed");
  a_timed_block: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_accumulation_mode_select && !manual_update |-> !do_update)
    else $error("timed update in manual mode");
  a_mux_connect: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 line_framer_connected == $past(mux_s2_ff & ~line_mux_bit))
    else $error("mux connect wrong");
  a_remote_loop: assert property (@(posedge clk) disable iff (!rst_b)
    remote_loop && link_tick ##1 $stable(loop_ff)
    |-> tx_line_pos_out == $past(link_s2_ff.line_pos))
    else $error("remote loop data");
  a_local_loop: assert property (@(posedge clk) disable iff (!rst_b)
    local_loop && link_tick |=> rx_framer_pos == $past(link_s2_ff.fmt_pos))
    else $error("local loop data");
  a_t1_period: assert property (@(posedge clk) disable iff (!rst_b)
    t1_mode && cfg_update_interval_select |-> period_frames == 13'd333)
    else $error("T1 short period");
  a_e1_period: assert property (@(posedge clk) disable iff (!rst_b)
    !t1_mode && cfg_update_interval_select |-> period_frames == 13'd500)
    else $error("E1 short period");
  c_timed: cover property (@(posedge clk) disable iff (!rst_b) timed_update);
  c_manual: cover property (@(posedge clk) disable iff (!rst_b)
    manual_update);
  c_chan: cover property (@(posedge clk) disable iff (!rst_b)
    chan_looped && link_tick);
endmodule : fecl_top

// ===== testbench/fecl_line_model.sv
// Line-side partner: free-running link clock, frame position and line data.
`timescale 1ns/1ps
module fecl_line_model import fecl_pkg::*; (
  input wire logic [8:0] frame_bits,
  output fecl_link_type link,
  output logic [8:0] bit_pos
);
  logic lclk;
  // The line clock is independent of anything the block recovers, so no
  // recovered clock is ever tied back into the transmit timing.
  initial begin
    lclk = 1'b0;
    #3;
    forever #40 lclk = ~lclk;
  end
  initial bit_pos = 9'h000;
  // Data moves on the falling edge so it is settled at every rising edge.
  always @(negedge lclk) begin
    bit_pos <= (bit_pos >= frame_bits - 9'h001) ? 9'h000 : bit_pos + 9'h001;
  end
  assign link = '{clk: lclk, frame_start: bit_pos == 9'h000,
    line_pos: bit_pos[0], line_neg: bit_pos[1],
    rx_data: bit_pos[2] ^ bit_pos[0], fmt_pos: ~bit_pos[0],
    fmt_neg: ~bit_pos[1], tx_serial: bit_pos[1] ^ bit_pos[2],
    tx_signaling: bit_pos[0]};
endmodule : fecl_line_model

// ===== testbench/framer_error_count_loopback_bench.sv
// Self-checking bench of the error-count and loopback block.
`timescale 1ns/1ps
`include "fecl_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module framer_error_count_loopback_bench import fecl_pkg::*;;
  logic clk, rst_b, t1_mode, reg_wr, reg_rd, line_mux_control;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
  fecl_link_type link_pins, s;
  fecl_events_type event_pins;
  logic tx_pos, tx_neg, rxf_pos, rxf_neg, fdata, regen, conn, jit, txrx, rxtx;
  logic [8:0] frame_bits, bit_pos, p;
  int fails, n_checks;
  fecl_top u_fecl_top (.clk(clk), .rst_b(rst_b), .t1_mode(t1_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_mux_control(line_mux_control), .link_pins(link_pins),
    .event_pins(event_pins), .tx_line_pos_out(tx_pos),
    .tx_line_neg_out(tx_neg), .rx_framer_pos(rxf_pos),
    .rx_framer_neg(rxf_neg), .formatter_data(fdata),
    .formatter_overhead_regen(regen), .line_framer_connected(conn),
    .jitter_atten_in_loop(jit), .tx_timing_from_rx(txrx),
    .rx_timing_from_tx(rxtx));
  fecl_line_model u_fecl_line_model (.frame_bits(frame_bits),
    .link(link_pins), .bit_pos(bit_pos));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task results;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask : rd
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rdv, e)
  endtask : rdchk
  task reg_check;
    for (int a = 65; a <= 76; a++) rdchk(a[7:0], 8'h00);
    rdchk(8'h50, 8'h00);
    wr(`FECL_OFF_LCV_HI, 8'hff);
    rdchk(`FECL_OFF_LCV_HI, 8'h00);
    wr(`FECL_OFF_CFG, 8'hff);
    rdchk(`FECL_OFF_CFG, 8'h7f);
    wr(`FECL_OFF_LOOP, 8'hff);
    rdchk(`FECL_OFF_LOOP, 8'h1f);
    wr(`FECL_OFF_LOOP, 8'h00);
    wr(`FECL_OFF_CHL1, 8'ha5);
    wr(`FECL_OFF_CHL2, 8'h5a);
    rdchk(`FECL_OFF_CHL1, 8'ha5);
    rdchk(`FECL_OFF_CHL2, 8'h5a);
  endtask : reg_check
  task manual_case(input logic t1, input logic [7:0] cfg,
                   input fecl_events_type e, input int k);
    logic [15:0] c [4];
    t1_mode <= t1;
    wr(`FECL_OFF_CFG, cfg | 8'h10);
    @(negedge link_pins.clk);
    event_pins <= e;
    repeat (k) @(negedge link_pins.clk);
    event_pins <= '0;
    repeat (8) @(posedge clk);
    wr(`FECL_OFF_CFG, cfg | 8'h50);
    // Software waits well over the settling time before reading back.
    repeat (4) @(posedge clk);
    c[0] = (t1 ? (e.bpv | (e.exz & cfg[0])) : (cfg[3] ? e.cv : e.bpv))
           ? k[15:0] : 16'h0000;
    c[1] = (e.ft_err | (e.fs_err & cfg[2])) ? k[15:0] : 16'h0000;
    c[2] = (cfg[1] ? e.mf_oos : (e.ft_err | e.fs_err)) ? k[15:0] : 16'h0000;
    c[3] = e.ebit ? k[15:0] : 16'h0000;
    for (int i = 0; i < 4; i++) begin
      rdchk(8'h42 + 8'(2 * i), c[i][15:8]);
      rdchk(8'h43 + 8'(2 * i), c[i][7:0]);
    end
  endtask : manual_case
  task mux_check;
    for (int i = 0; i < 4; i++) begin
      line_mux_control <= i[0];
      wr(`FECL_OFF_LOOP, {3'h0, i[1], 4'h0});
      repeat (6) @(posedge clk);
      `CHK(conn, i[0] & ~i[1])
    end
  endtask : mux_check
  task stream(input logic t1, input logic [7:0] lv);
    logic ovh, lp;
    logic [1:0] rx_exp;
    int ch;
    t1_mode <= t1;
    frame_bits <= t1 ? 9'd193 : 9'd256;
    wr(`FECL_OFF_LOOP, lv);
    repeat (260) @(posedge link_pins.clk);
    `CHK({jit, txrx, rxtx}, {lv[3], lv[1], lv[0]})
    for (int i = 0; i < 200; i++) begin
      @(posedge link_pins.clk);
      if (i > 0) begin
        ovh = t1 ? (p == 9'd0) : (p < 9'd8);
        ch = (int'(p) - (t1 ? 1 : 8)) / 8;
        if (lv[1]) begin
          `CHK(regen, ovh)
          `CHK(fdata, ovh ? 1'b0 : s.rx_data)
        end else begin
          `CHK(regen, 1'b0)
          lp = !ovh && ch < 16 && ((16'h5aa5 >> ch) & 1) != 0;
          `CHK(fdata, lp ? s.rx_data : s.tx_serial)
        end
        if (lv[2]) `CHK({tx_pos, tx_neg}, {s.line_pos, s.line_neg})
        else if (lv[0] && t1) `CHK(tx_pos ^ tx_neg, 1'b1)
        else if (!lv[1])
          `CHK({tx_pos, tx_neg}, {s.fmt_pos, s.fmt_neg})
        rx_exp = (lv[3] | lv[0]) ? {s.fmt_pos, s.fmt_neg}
                                 : {s.line_pos, s.line_neg};
        `CHK({rxf_pos, rxf_neg}, rx_exp)
      end
      p = bit_pos;
      s = link_pins;
    end
  endtask : stream
  task timed(input logic t1, input logic [15:0] e);
    logic ok;
    ok = 1'b0;
    t1_mode <= t1;
    frame_bits <= 9'd2;
    wr(`FECL_OFF_CFG, 8'h20);
    @(negedge link_pins.clk);
    event_pins <= 7'h40;
    // Two reads may straddle a boundary, so poll until one pair matches.
    for (int i = 0; i < 8000 && !ok; i++) begin
      rd(`FECL_OFF_LCV_HI);
      ok = rdv === e[15:8];
      rd(`FECL_OFF_LCV_LO);
      ok = ok && rdv === e[7:0];
    end
    `CHK(ok, 1'b1)
    event_pins <= '0;
  endtask : timed
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, line_mux_control} = 4'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    t1_mode = 1'b1;
    event_pins = '0;
    frame_bits = 9'd193;
    fails = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    reg_check();
    manual_case(1'b1, 8'h00, 7'h40, 300);
    manual_case(1'b1, 8'h00, 7'h10, 5);
    manual_case(1'b1, 8'h01, 7'h10, 6);
    manual_case(1'b1, 8'h00, 7'h08, 7);
    manual_case(1'b1, 8'h00, 7'h04, 4);
    manual_case(1'b1, 8'h04, 7'h04, 5);
    manual_case(1'b1, 8'h02, 7'h02, 3);
    manual_case(1'b1, 8'h00, 7'h02, 4);
    manual_case(1'b0, 8'h00, 7'h40, 5);
    manual_case(1'b0, 8'h08, 7'h40, 6);
    manual_case(1'b0, 8'h00, 7'h20, 3);
    manual_case(1'b0, 8'h08, 7'h20, 4);
    manual_case(1'b0, 8'h00, 7'h01, 9);
    mux_check();
    stream(1'b1, 8'h00);
    stream(1'b0, 8'h00);
    stream(1'b1, 8'h04);
    stream(1'b1, 8'h08);
    stream(1'b1, 8'h01);
    stream(1'b0, 8'h01);
    stream(1'b1, 8'h02);
    stream(1'b0, 8'h02);
    timed(1'b1, 16'd666);
    timed(1'b0, 16'd1000);
    results();
  end
endmodule : framer_error_count_loopback_bench
